// [hdl/ubg_pkg.sv]
package ubg_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_RECEIVE_DATA = 8'h1a;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BAUD_RATE_DIVISOR = 8'h99;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int RX_DONE_FLAG_BIT = 5;
  localparam int RX_IRQ_ENABLE_BIT = 5;
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_RX_ENABLE_BIT = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int FRAMING_ERROR_FLAG_BIT = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int RX_NINTH_BIT_BIT = 0;
  localparam int CLOCK_SOURCE_MASTER_BIT = 7;
  localparam int SYNC_SELECT_BIT = 4;
  localparam int HIGH_SPEED_SELECT_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_ENABLES_ONE = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_RATE_DIVISOR = 8'h00;
  localparam logic [7:0] RST_RECEIVE_DATA = 8'h00;
  // ---------------------------------------------------------------
  // baud prescale (oscillator clocks per divisor step, minus one)
  // ---------------------------------------------------------------
  localparam logic [5:0] PRESCALE_ASYNC_LOW = 6'h3f;
  localparam logic [5:0] PRESCALE_ASYNC_HIGH = 6'h0f;
  localparam logic [5:0] PRESCALE_SYNC_HALF = 6'h01;
endpackage : ubg_pkg

// [hdl/ubg_usart_rx.sv]
`timescale 1ns/1ns
// Functional notes
// - free-running 8-bit baud timer, divisor 0..255
// - async rate osc/64(X+1) or osc/16(X+1)
// - sync rate osc/4(X+1), high-speed ignored
// - formulas apply only as clock master
// - divisor write resets baud timer at once
// - data level by three-sample majority
// - sync master samples on clock falling edge
// - single enable one word; continuous until cleared
// - both enables set means continuous
// - last bit moves word, sets done flag
// - receive irq only when irq enable set
// - done flag read-only, clears when buffer empty
// - two-entry buffer, third word may shift
// - full at third word: overrun, word lost
// - overrun blocks moves; cleared via continuous enable
// - ninth bit buffered; buffer read updates it
module ubg_usart_rx
  import ubg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // serial line
  input wire logic rx_data_pin_i,
  output logic serial_clk_o,
  output logic serial_clk_oe_o,
  // interrupt to processor
  output logic rx_irq_o
);
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic [7:0] interrupt_control;
    logic [7:0] pie;
    logic [7:0] receive_status_control;
    logic [7:0] transmit_status_control;
    logic [7:0] divisor;
    logic [7:0] baud_cnt;
    logic [5:0] pre_cnt;
    logic sclk;
    logic sclk_oe;
    logic busy;
    logic single_done;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic [2:0] sync_pipe;
    logic [2:0] samples;
    logic [8:0] fifo0;
    logic [8:0] fifo1;
    logic [1:0] count;
    logic irq;
  } ubg_state_t;

  ubg_state_t cur;
  ubg_state_t nxt;

  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic [5:0] prescale;
  logic baud_tick;
  logic rx_level;
  logic sync_mode;
  logic master;
  logic run_en;
  logic [3:0] word_bits;
  logic [8:0] word;

  assign idx = adr_i[9:2];
  assign wr_en = cyc_i && stb_i && we_i && sel_i[0] && !cur.ack;
  assign rd_en = cyc_i && stb_i && !we_i && !cur.ack;
  assign sync_mode = cur.transmit_status_control[SYNC_SELECT_BIT];
  assign master = cur.transmit_status_control[CLOCK_SOURCE_MASTER_BIT];
  assign rx_level = (cur.samples[0] & cur.samples[1]) |
                    (cur.samples[1] & cur.samples[2]) |
                    (cur.samples[0] & cur.samples[2]);
  assign word_bits = cur.receive_status_control[NINE_BIT_RX_ENABLE_BIT] ? 4'h9 : 4'h8;
  assign run_en = sync_mode && master &&
                  cur.receive_status_control[SERIAL_PORT_ENABLE_BIT] &&
                  (cur.receive_status_control[CONTINUOUS_RECEIVE_ENABLE_BIT] ||
                   (cur.receive_status_control[SINGLE_RECEIVE_ENABLE_BIT] &&
                    !cur.single_done));

  // ---------------------------------------------------------------
  // prescale select
  // ---------------------------------------------------------------
  always_comb begin
    if (sync_mode) begin
      prescale = PRESCALE_SYNC_HALF;
    end else if (cur.transmit_status_control[HIGH_SPEED_SELECT_BIT]) begin
      prescale = PRESCALE_ASYNC_HIGH;
    end else begin
      prescale = PRESCALE_ASYNC_LOW;
    end
  end

  assign baud_tick = (cur.pre_cnt == prescale) &&
                     (cur.baud_cnt == cur.divisor);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt = cur;
    word = cur.shift;
    nxt.ack = cyc_i && stb_i && !cur.ack;
    nxt.sync_pipe = {cur.sync_pipe[1:0], rx_data_pin_i};
    // sync plus majority lag: half period needs five clocks, divisor >= 2
    nxt.samples = {cur.samples[1:0], cur.sync_pipe[1]};

    // free-running baud timer
    if (cur.pre_cnt >= prescale) begin
      nxt.pre_cnt = 6'h00;
      if (cur.baud_cnt >= cur.divisor) begin
        nxt.baud_cnt = 8'h00;
      end else begin
        nxt.baud_cnt = cur.baud_cnt + 8'h01;
      end
    end else begin
      nxt.pre_cnt = cur.pre_cnt + 6'h01;
    end

    // serial clock and shift
    if (!run_en && !cur.busy) begin
      nxt.sclk = 1'b0;
      nxt.sclk_oe = run_en;
      nxt.bit_cnt = 4'h0;
    end else if (baud_tick) begin
      nxt.sclk_oe = 1'b1;
      nxt.busy = 1'b1;
      nxt.sclk = !cur.sclk;
      if (cur.sclk) begin
        // falling edge: sample line
        word = {rx_level, cur.shift[8:1]};
        if (!cur.receive_status_control[NINE_BIT_RX_ENABLE_BIT]) begin
          word = {1'b0, rx_level, cur.shift[7:1]};
        end
        nxt.shift = word;
        nxt.bit_cnt = cur.bit_cnt + 4'h1;
        if (cur.bit_cnt + 4'h1 == word_bits) begin
          nxt.bit_cnt = 4'h0;
          nxt.busy = 1'b0;
          if (!run_en || !cur.receive_status_control[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
            nxt.sclk_oe = 1'b0;
          end
          if (cur.receive_status_control[SINGLE_RECEIVE_ENABLE_BIT] &&
              !cur.receive_status_control[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
            nxt.single_done = 1'b1;
          end
          if (cur.receive_status_control[OVERRUN_ERROR_FLAG_BIT]) begin
            nxt.count = cur.count;
          end else if (cur.count == 2'd2) begin
            nxt.receive_status_control[OVERRUN_ERROR_FLAG_BIT] = 1'b1;
          end else if (cur.count == 2'd1) begin
            nxt.fifo1 = word;
            nxt.count = 2'd2;
          end else begin
            nxt.fifo0 = word;
            nxt.count = 2'd1;
          end
        end
      end
    end

    // buffer read pops head
    if (rd_en && idx == IDX_RECEIVE_DATA && cur.count != 2'd0) begin
      nxt.fifo0 = cur.fifo1;
      if (cur.count == 2'd2 && nxt.count == 2'd2) begin
        nxt.count = 2'd1;
      end else if (cur.count == 2'd1 && nxt.count == 2'd1) begin
        nxt.count = 2'd0;
      end
      if (nxt.count == 2'd2 && cur.count == 2'd1) begin
        nxt.fifo0 = word;
        nxt.count = 2'd1;
      end
    end

    // register writes
    if (wr_en) begin
      case (idx)
        IDX_INTERRUPT_CONTROL: nxt.interrupt_control = dat_i[7:0];
        IDX_PERIPHERAL_ENABLES_ONE: nxt.pie = dat_i[7:0];
        IDX_RECEIVE_STATUS_CONTROL: begin
          nxt.receive_status_control[7:4] = dat_i[7:4];
          // a fresh overrun in the same cycle wins over the clear
          if (!dat_i[CONTINUOUS_RECEIVE_ENABLE_BIT] &&
              cur.receive_status_control[OVERRUN_ERROR_FLAG_BIT]) begin
            nxt.receive_status_control[OVERRUN_ERROR_FLAG_BIT] = 1'b0;
          end
          if (!dat_i[SINGLE_RECEIVE_ENABLE_BIT]) begin
            nxt.single_done = 1'b0;
          end
        end
        IDX_TRANSMIT_STATUS_CONTROL: begin
          nxt.transmit_status_control[7:2] = {dat_i[7:3] & 5'h1f, dat_i[2]} & 6'h3d;
        end
        IDX_BAUD_RATE_DIVISOR: begin
          nxt.divisor = dat_i[7:0];
          nxt.baud_cnt = 8'h00;
          nxt.pre_cnt = 6'h00;
        end
        default: nxt.interrupt_control = nxt.interrupt_control;
      endcase
    end

    nxt.receive_status_control[RX_NINTH_BIT_BIT] = nxt.fifo0[8];
    nxt.receive_status_control[3] = 1'b0;
    nxt.receive_status_control[FRAMING_ERROR_FLAG_BIT] = 1'b0;
    nxt.irq = (nxt.count != 2'd0) && nxt.pie[RX_IRQ_ENABLE_BIT];

    // read data
    nxt.dat = 32'h0000_0000;
    if (rd_en) begin
      case (idx)
        IDX_INTERRUPT_CONTROL: nxt.dat[7:0] = cur.interrupt_control;
        IDX_PERIPHERAL_FLAGS_ONE: begin
          nxt.dat[RX_DONE_FLAG_BIT] = cur.count != 2'd0;
        end
        IDX_RECEIVE_STATUS_CONTROL: nxt.dat[7:0] = cur.receive_status_control;
        IDX_RECEIVE_DATA: nxt.dat[7:0] = cur.fifo0[7:0];
        IDX_PERIPHERAL_ENABLES_ONE: nxt.dat[7:0] = cur.pie;
        IDX_TRANSMIT_STATUS_CONTROL: nxt.dat[7:0] = cur.transmit_status_control;
        IDX_BAUD_RATE_DIVISOR: nxt.dat[7:0] = cur.divisor;
        default: nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.interrupt_control <= RST_INTERRUPT_CONTROL;
      cur.pie <= RST_PERIPHERAL_ENABLES_ONE;
      cur.receive_status_control <= RST_RECEIVE_STATUS_CONTROL;
      cur.transmit_status_control <= RST_TRANSMIT_STATUS_CONTROL;
      cur.divisor <= RST_BAUD_RATE_DIVISOR;
      cur.fifo0 <= {1'b0, RST_RECEIVE_DATA};
    end else begin
      cur <= nxt;
    end
  end

  assign dat_o = cur.dat;
  assign ack_o = cur.ack;
  assign serial_clk_o = cur.sclk;
  assign serial_clk_oe_o = cur.sclk_oe;
  assign rx_irq_o = cur.irq;
endmodule : ubg_usart_rx

// [verif/ubg_usart_rx_sva.sv]
`timescale 1ns/1ns
module ubg_usart_rx_sva
  import ubg_pkg::*;
(
  // watched ports
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i, dat_o,
  input wire logic rx_data_pin_i, serial_clk_o, serial_clk_oe_o, rx_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data");
  property p_unmap;
    ack_o && !we_i && adr_i[9:2] == 8'h00 |-> dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_idle; !serial_clk_oe_o |-> !serial_clk_o; endproperty
  a_idle: assert property (p_idle) else $error("clk idle");
  property p_hold; $rose(serial_clk_o) |=> serial_clk_o; endproperty
  a_hold: assert property (p_hold) else $error("short high");
  property p_half; $rose(serial_clk_o) |-> ##[1:512] $fell(serial_clk_o);
  endproperty
  a_half: assert property (p_half) else $error("stuck high");
  property p_mask;
    ack_o && we_i && sel_i[0] && !dat_i[5] &&
      adr_i[9:2] == IDX_PERIPHERAL_ENABLES_ONE |-> ##2 !rx_irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("irq unmasked");
  property p_rst;
    $fell(rst_i) |-> !rx_irq_o && !serial_clk_oe_o && !ack_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset out");
endmodule : ubg_usart_rx_sva

// [verif/ubg_sync_slave.sv]
`timescale 1ns/1ns
module ubg_sync_slave (
  // serial clock from the block
  input wire logic sclk_i,
  input wire logic oe_i,
  // data to the block
  output logic sdo_o
);
  logic [7:0] words[$];
  logic [7:0] cur = 8'h00;
  int n = 0;
  initial sdo_o = 1'b1;
  // lsb first, launched on rising edge, stable at falling
  always @(posedge sclk_i) begin
    if (n == 0 && words.size() > 0) cur = words.pop_front();
    sdo_o = cur[n];
    n = (n + 1) % 8;
  end
  // released line shows the inverse level
  always @(negedge oe_i) sdo_o = ~sdo_o;
endmodule : ubg_sync_slave

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top
  import ubg_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, rx_pin, sclk, sclk_oe, irq;
  logic [7:0] rd, b;
  logic [7:0] exp_q[$];
  int fails = 0, checks_done = 0, seed = 40392, rises = 0, x, k;
  time t_prev = 0, t_last = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge sclk) begin
    rises++;
    t_prev = t_last;
    t_last = $time;
  end
  ubg_usart_rx u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_data_pin_i(rx_pin),
    .serial_clk_o(sclk), .serial_clk_oe_o(sclk_oe), .rx_irq_o(irq));
  ubg_sync_slave u_slave (.sclk_i(sclk), .oe_i(sclk_oe), .sdo_o(rx_pin));
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    checks_done++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    dat_i <= {24'h0, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    rd = dat_o[7:0];
    if (i == 50) begin
      fails++;
      finish_test();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdchk
  task automatic wait_until(input int n);
    int i;
    for (i = 0; i < 20000 && rises < n; i++) @(posedge clk_i);
    if (rises < n) begin
      fails++;
      finish_test();
    end
  endtask : wait_until
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h00, 8'h00);
    rdchk(IDX_TRANSMIT_STATUS_CONTROL, RST_TRANSMIT_STATUS_CONTROL);
    rdchk(IDX_BAUD_RATE_DIVISOR, RST_BAUD_RATE_DIVISOR);
    rdchk(IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    rdchk(IDX_RECEIVE_DATA, RST_RECEIVE_DATA);
    b = 8'($random(seed));
    wb(1'b1, IDX_BAUD_RATE_DIVISOR, b);
    wb(1'b1, IDX_INTERRUPT_CONTROL, 8'hc0);
    rdchk(IDX_INTERRUPT_CONTROL, 8'hc0);
    rdchk(IDX_BAUD_RATE_DIVISOR, b);
    for (x = 1; x < 4; x += 2) begin
      wb(1'b1, IDX_BAUD_RATE_DIVISOR, 8'(x + 2));
      wb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
      wb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
      wb(1'b1, IDX_PERIPHERAL_ENABLES_ONE, 8'h20);
      rises = 0;
      for (k = 0; k < x; k++) begin
        b = 8'($random(seed));
        u_slave.words.push_back(b);
        exp_q.push_back(b);
      end
      // single word first, then both enables for a full buffer
      wb(1'b1, IDX_RECEIVE_STATUS_CONTROL, x == 1 ? 8'ha0 : 8'hb0);
      wait_until(x == 1 ? 8 : 26);
      repeat (40) @(posedge clk_i);
      chk(8'((t_last - t_prev) / 50), 8'(4 * (x + 3)));
      chk({7'h0, irq}, 8'h01);
      if (x == 1) begin
        chk(rises[7:0], 8'd8);
        rdchk(IDX_PERIPHERAL_FLAGS_ONE, 8'h20);
      end else begin
        wb(1'b0, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        chk(rd & 8'h02, 8'h02);
        rdchk(IDX_RECEIVE_DATA, exp_q.pop_front());
      end
      rdchk(IDX_RECEIVE_DATA, exp_q.pop_front());
      if (x != 1) wait_until(rises + 12);
      rdchk(IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
      wb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
      wb(1'b0, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
      chk(rd & 8'h02, 8'h00);
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
    wb(1'b1, IDX_PERIPHERAL_ENABLES_ONE, 8'h00);
    finish_test();
  end
  initial begin
    #4000000;
    fails++;
    finish_test();
  end
endmodule : tb_top
bind ubg_usart_rx ubg_usart_rx_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .rx_data_pin_i(rx_data_pin_i), .serial_clk_o(serial_clk_o),
  .serial_clk_oe_o(serial_clk_oe_o), .rx_irq_o(rx_irq_o));
